// >>> pvcr_pkg.sv
// Package for the vendor control register slice: offsets, reset values, field positions and carrier types.
// Assumes a 5-bit management register address and 16-bit register data, as on the serial management port.
package pvcr_pkg;
  localparam int REG_AW = 5;
  localparam int REG_DW = 16;

  localparam logic [REG_AW-1:0] ADDR_DIGITAL_POWER_CONTROL = 5'h10;
  localparam logic [REG_AW-1:0] ADDR_ANALOG_FRONTEND_CONTROL = 5'h11;
  localparam logic [REG_AW-1:0] ADDR_SYMBOL_ERROR_FRAME_COUNTER = 5'h15;
  localparam logic [REG_AW-1:0] ADDR_STRAP_OVERRIDE_CONTROL = 5'h16;

  localparam int BIT_PLL_OFF = 4;
  localparam int BIT_SLOW_OSC_ENABLE = 5;
  localparam int BIT_WAKE_EVENT_ENABLE = 15;
  localparam int BIT_READ_ONLY_16 = 10;
  localparam int BIT_BROADCAST_ADDRESS_DISABLE = 9;

  localparam logic [REG_DW-1:0] RST_DIGITAL_POWER_CONTROL = 16'h0000;
  localparam logic [REG_DW-1:0] RST_ANALOG_FRONTEND_CONTROL = 16'h0000;
  localparam logic [REG_DW-1:0] RST_SYMBOL_ERROR_FRAME_COUNTER = 16'h0000;
  // Bit 15 is replaced by the strap once it has been sampled
  localparam logic [REG_DW-1:0] RST_STRAP_OVERRIDE_CONTROL = 16'h0001;
  localparam logic [REG_DW-1:0] WMASK_STRAP_OVERRIDE_CONTROL = 16'hfbff;
  localparam logic [REG_DW-1:0] COUNTER_MAX = 16'hffff;

  // One management access as decoded by the serial frame engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } pvcr_mgmt_req_t;

  // Wake output pins 21 and 30, one bit each
  typedef struct packed {
    logic pin21;
    logic pin30;
  } pvcr_wake_pins_t;
endpackage : pvcr_pkg

// >>> pvcr_vendor_regs.sv
// Vendor control registers 10h, 11h, 15h and 16h of a 10/100 transceiver, plus the logic they steer.
// Assumes the serial management frame engine hands over one decoded access per cycle on CORE_CLK,
// and that energy-detect state, symbol-error frame pulses and wake events come from CORE_CLK logic.
// Strap pins are asynchronous and pass a two-flop synchroniser.
module pvcr_vendor_regs
  import pvcr_pkg::*;
(
  input wire logic CORE_CLK, // Core clock, 10 MHz
  input wire logic RST_N, // Synchronous reset, active low
  input wire pvcr_mgmt_req_t MGMT_REQ, // Decoded management access, rd/wr one-cycle pulses
  output logic [REG_DW-1:0] MGMT_RDATA, // Read data, valid the cycle after rd
  input wire logic ENERGY_DETECT_POWER_DOWN, // Device is in energy-detect power-down
  input wire logic AFE_SW_POWER_DOWN, // Software power-down request from basic control
  input wire logic RECEIVE_SYMBOL_ERROR, // One-cycle pulse per received frame with symbol error
  input wire logic POWER_MGMT_WAKE_EVENT, // Wake event detected by the wake-on-LAN logic
  input wire logic [1:0] WAKE_PIN_MODE, // Bits 15:14 of device 1Fh register 0
  input wire logic WAKE_ENABLE_STRAP, // Wake-enable strapping pin, asynchronous
  input wire logic BROADCAST_ADDRESS_DISABLE_STRAP, // Broadcast-off strapping pin, asynchronous
  output logic PLL_OFF, // PLL switched off
  output logic SLOW_OSC_SELECT, // Internal slow oscillator selected
  output logic REFERENCE_CRYSTAL_INPUT_DISCONNECT, // Reference crystal input disconnected
  output logic ANALOG_FRONTEND_POWER_DOWN, // Analog frontend powered down
  output logic BROADCAST_ADDRESS_DISABLE, // Management address 0 is not broadcast
  output pvcr_wake_pins_t WAKE_PINS // Wake output pins 21 and 30
);

  logic [REG_DW-1:0] digital_power_control;
  logic [REG_DW-1:0] analog_frontend_control;
  logic [REG_DW-1:0] symbol_error_frame_counter;
  logic [REG_DW-1:0] strap_override_control;
  logic wake_strap_s1;
  logic wake_strap_s2;
  logic bcast_strap_s1;
  logic bcast_strap_s2;
  logic strap_loaded;

  wire wr_dig = MGMT_REQ.wr && (MGMT_REQ.addr == ADDR_DIGITAL_POWER_CONTROL);
  wire wr_afe = MGMT_REQ.wr && (MGMT_REQ.addr == ADDR_ANALOG_FRONTEND_CONTROL);
  wire wr_strap = MGMT_REQ.wr && (MGMT_REQ.addr == ADDR_STRAP_OVERRIDE_CONTROL);
  wire rd_counter = MGMT_REQ.rd && (MGMT_REQ.addr == ADDR_SYMBOL_ERROR_FRAME_COUNTER);
  wire wake_en = strap_override_control[BIT_WAKE_EVENT_ENABLE];
  wire slow_osc_en = analog_frontend_control[BIT_SLOW_OSC_ENABLE];
  wire counter_full = (symbol_error_frame_counter == COUNTER_MAX);

  logic [REG_DW-1:0] read_mux;
  always_comb
  begin
    if (MGMT_REQ.addr == ADDR_DIGITAL_POWER_CONTROL)
      read_mux = digital_power_control;
    else if (MGMT_REQ.addr == ADDR_ANALOG_FRONTEND_CONTROL)
      read_mux = analog_frontend_control;
    else if (MGMT_REQ.addr == ADDR_SYMBOL_ERROR_FRAME_COUNTER)
      read_mux = symbol_error_frame_counter;
    else if (MGMT_REQ.addr == ADDR_STRAP_OVERRIDE_CONTROL)
      read_mux = strap_override_control;
    else
      read_mux = '0;
  end

  // An event in the reading cycle is counted after the clear, so it is never lost
  logic [REG_DW-1:0] next_counter;
  always_comb
  begin
    if (rd_counter)
      next_counter = RECEIVE_SYMBOL_ERROR ? 16'h0001 : 16'h0000;
    else if (RECEIVE_SYMBOL_ERROR && !counter_full)
      next_counter = symbol_error_frame_counter + 16'h0001;
    else
      next_counter = symbol_error_frame_counter;
  end

  // Strap synchronisers are not reset so they are already settled when reset releases
  always_ff @(posedge CORE_CLK)
  begin
    wake_strap_s1 <= WAKE_ENABLE_STRAP;
    wake_strap_s2 <= wake_strap_s1;
    bcast_strap_s1 <= BROADCAST_ADDRESS_DISABLE_STRAP;
    bcast_strap_s2 <= bcast_strap_s1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      digital_power_control <= RST_DIGITAL_POWER_CONTROL;
      analog_frontend_control <= RST_ANALOG_FRONTEND_CONTROL;
      symbol_error_frame_counter <= RST_SYMBOL_ERROR_FRAME_COUNTER;
      strap_override_control <= RST_STRAP_OVERRIDE_CONTROL;
      strap_loaded <= 1'b0;
      MGMT_RDATA <= '0;
    end
    else
    begin
      symbol_error_frame_counter <= next_counter;
      if (MGMT_REQ.rd)
        MGMT_RDATA <= read_mux;
      if (wr_dig)
        digital_power_control <= MGMT_REQ.wdata;
      if (wr_afe)
        analog_frontend_control <= MGMT_REQ.wdata;
      // Strap sampling on the first edge after release wins over a write in that cycle
      if (!strap_loaded)
      begin
        strap_override_control[BIT_WAKE_EVENT_ENABLE] <= wake_strap_s2;
        strap_loaded <= 1'b1;
      end
      else if (wr_strap)
        strap_override_control <= (MGMT_REQ.wdata & WMASK_STRAP_OVERRIDE_CONTROL)
          | (strap_override_control & ~WMASK_STRAP_OVERRIDE_CONTROL);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      PLL_OFF <= 1'b0;
      SLOW_OSC_SELECT <= 1'b0;
      REFERENCE_CRYSTAL_INPUT_DISCONNECT <= 1'b0;
      ANALOG_FRONTEND_POWER_DOWN <= 1'b0;
      BROADCAST_ADDRESS_DISABLE <= 1'b0;
      WAKE_PINS <= '0;
    end
    else
    begin
      PLL_OFF <= digital_power_control[BIT_PLL_OFF] && ENERGY_DETECT_POWER_DOWN;
      SLOW_OSC_SELECT <= slow_osc_en;
      REFERENCE_CRYSTAL_INPUT_DISCONNECT <= slow_osc_en;
      ANALOG_FRONTEND_POWER_DOWN <= slow_osc_en || AFE_SW_POWER_DOWN;
      BROADCAST_ADDRESS_DISABLE <= strap_override_control[BIT_BROADCAST_ADDRESS_DISABLE]
        || bcast_strap_s2;
      // Mode 00 disables both pins; 01 pin 21, 10 pin 30, 11 both
      WAKE_PINS.pin21 <= wake_en && WAKE_PIN_MODE[0] && POWER_MGMT_WAKE_EVENT;
      WAKE_PINS.pin30 <= wake_en && WAKE_PIN_MODE[1] && POWER_MGMT_WAKE_EVENT;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  a_pll_off_on: assert property ((digital_power_control[BIT_PLL_OFF] && ENERGY_DETECT_POWER_DOWN) |=> PLL_OFF)
    else $error("PLL not switched off in energy-detect power-down");
  a_pll_kept_on: assert property (!digital_power_control[BIT_PLL_OFF] |=> !PLL_OFF)
    else $error("PLL switched off while control bit clear");
  a_slow_osc_select: assert property (slow_osc_en |=> SLOW_OSC_SELECT && REFERENCE_CRYSTAL_INPUT_DISCONNECT)
    else $error("Slow oscillator not selected");
  a_afe_auto_pd: assert property (slow_osc_en |=> ANALOG_FRONTEND_POWER_DOWN)
    else $error("Analog frontend not powered down in slow-oscillator mode");
  a_counter_incr: assert property ((RECEIVE_SYMBOL_ERROR && !rd_counter && !counter_full)
    |=> symbol_error_frame_counter == $past(symbol_error_frame_counter) + 16'h0001)
    else $error("Counter did not count a symbol-error frame");
  a_counter_wr_ignored: assert property ((MGMT_REQ.wr && !RECEIVE_SYMBOL_ERROR && !rd_counter)
    |=> $stable(symbol_error_frame_counter))
    else $error("Write changed the counter");
  a_read_clears: assert property (rd_counter |=> (MGMT_RDATA == $past(symbol_error_frame_counter))
    && (symbol_error_frame_counter == {15'h0000, $past(RECEIVE_SYMBOL_ERROR)}))
    else $error("Counter read did not return and clear the count");
  a_wake_gated: assert property (!wake_en |=> WAKE_PINS == '0)
    else $error("Wake pin driven while wake enable clear");
  a_strap_load: assert property (!strap_loaded |=> strap_loaded && (wake_en == $past(wake_strap_s2)))
    else $error("Wake enable not loaded from strap");
  a_bcast_override: assert property (strap_override_control[BIT_BROADCAST_ADDRESS_DISABLE]
    |=> BROADCAST_ADDRESS_DISABLE)
    else $error("Broadcast override not applied");

  // Saturation, which the bench cannot reach cheaply, plus the quiet read clear and idle hold that it also checks
  a_counter_saturate: assert property ((RECEIVE_SYMBOL_ERROR && counter_full && !rd_counter)
    |=> counter_full)
    else $error("Counter wrapped instead of saturating");
  a_read_clear_idle: assert property ((rd_counter && !RECEIVE_SYMBOL_ERROR)
    |=> symbol_error_frame_counter == 16'h0000)
    else $error("Counter not zero after a quiet read");
  a_counter_hold: assert property ((!RECEIVE_SYMBOL_ERROR && !rd_counter)
    |=> $stable(symbol_error_frame_counter))
    else $error("Counter moved without an event or a read");

  a_pll_energy_detect_power_down_gate: assert property (!ENERGY_DETECT_POWER_DOWN
    |=> !PLL_OFF)
    else $error("PLL switched off outside energy-detect power-down");
  a_slow_osc_off: assert property (!slow_osc_en
    |=> !SLOW_OSC_SELECT && !REFERENCE_CRYSTAL_INPUT_DISCONNECT)
    else $error("Slow oscillator selected while disabled");
  a_afe_pd_source: assert property ((!slow_osc_en && !AFE_SW_POWER_DOWN)
    |=> !ANALOG_FRONTEND_POWER_DOWN)
    else $error("Analog frontend powered down with no cause");

  a_wake_pin21: assert property ((wake_en && WAKE_PIN_MODE[0] && POWER_MGMT_WAKE_EVENT)
    |=> WAKE_PINS.pin21)
    else $error("Wake pin 21 not driven");
  a_wake_pin30: assert property ((wake_en && WAKE_PIN_MODE[1] && POWER_MGMT_WAKE_EVENT)
    |=> WAKE_PINS.pin30)
    else $error("Wake pin 30 not driven");
  a_wake_no_event: assert property (!POWER_MGMT_WAKE_EVENT
    |=> WAKE_PINS == '0)
    else $error("Wake pin driven with no wake event");

  // The strap keeps working after reset, so a later pin change is still honoured
  a_bcast_strap_live: assert property (bcast_strap_s2
    |=> BROADCAST_ADDRESS_DISABLE)
    else $error("Broadcast strap not applied");
  a_bcast_clear: assert property ((!strap_override_control[BIT_BROADCAST_ADDRESS_DISABLE] && !bcast_strap_s2)
    |=> !BROADCAST_ADDRESS_DISABLE)
    else $error("Broadcast disabled with no cause");
  a_readonly_bit: assert property (strap_override_control[BIT_READ_ONLY_16] == 1'b0)
    else $error("Read-only bit of strap override register set");
  a_rdata_hold: assert property (!MGMT_REQ.rd
    |=> $stable(MGMT_RDATA))
    else $error("Read data changed without a read");

  c_counter_saturated: cover property (counter_full && RECEIVE_SYMBOL_ERROR);
  c_counter_read: cover property (RECEIVE_SYMBOL_ERROR ##[1:20] rd_counter);
  c_read_with_event: cover property (rd_counter && RECEIVE_SYMBOL_ERROR);
  c_slow_osc_entry: cover property ($rose(ANALOG_FRONTEND_POWER_DOWN) && SLOW_OSC_SELECT);
  c_wake_pin: cover property (WAKE_PINS.pin21 || WAKE_PINS.pin30);
endmodule : pvcr_vendor_regs

// >>> tb.sv
// Self-checking testbench for the vendor control register slice.
// Assumes pvcr_pkg and pvcr_vendor_regs are compiled first; all inputs change at the falling edge.
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb
  import pvcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pvcr_mgmt_req_t req = '0;
  logic [REG_DW-1:0] rdata;
  logic energy_detect_power_down = 1'b0;
  logic rx_err = 1'b0;
  logic wake_ev = 1'b0;
  logic [1:0] pin_mode = 2'h0;
  logic plloff, slow_osc, xtal_off, afe_pd, bcast_off;
  pvcr_wake_pins_t pins;
  int n_fail = 0;
  int samples_checked = 0;
  logic [REG_DW-1:0] got;

  // Straps tied: wake enable strapped high so the reset load of bit 15 is visible
  pvcr_vendor_regs u_pvcr_vendor_regs (.CORE_CLK(core_clk), .RST_N(rst_n), .MGMT_REQ(req), .MGMT_RDATA(rdata),
    .ENERGY_DETECT_POWER_DOWN(energy_detect_power_down), .AFE_SW_POWER_DOWN(1'b0), .RECEIVE_SYMBOL_ERROR(rx_err),
    .POWER_MGMT_WAKE_EVENT(wake_ev), .WAKE_PIN_MODE(pin_mode), .WAKE_ENABLE_STRAP(1'b1),
    .BROADCAST_ADDRESS_DISABLE_STRAP(1'b0), .PLL_OFF(plloff), .SLOW_OSC_SELECT(slow_osc),
    .REFERENCE_CRYSTAL_INPUT_DISCONNECT(xtal_off), .ANALOG_FRONTEND_POWER_DOWN(afe_pd),
    .BROADCAST_ADDRESS_DISABLE(bcast_off), .WAKE_PINS(pins));

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(negedge core_clk);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask : wr_reg

  // Read data holds until the next read, so one spare cycle before sampling is safe
  task automatic rd_reg(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    @(negedge core_clk);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge core_clk);
    req.rd = 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd_reg

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    $display("MISMATCH watchdog expected end seen hang");
    stop_test();
  end

  initial
  begin
    step(5);
    rst_n = 1'b1;
    step(3);
    rd_reg(ADDR_DIGITAL_POWER_CONTROL, got); `CHK("reg10", 16'h0000, got)
    rd_reg(ADDR_ANALOG_FRONTEND_CONTROL, got); `CHK("reg11", 16'h0000, got)
    rd_reg(ADDR_STRAP_OVERRIDE_CONTROL, got); `CHK("reg16", 16'h8001, got)
    rd_reg(5'h01, got); `CHK("unmapped", 16'h0000, got)
    `CHK("pll_off", 1'b0, plloff)
    `CHK("bcast_off", 1'b0, bcast_off)
    $display("test reset done");
    energy_detect_power_down = 1'b1;
    step(2); `CHK("pll_off", 1'b0, plloff)
    wr_reg(ADDR_DIGITAL_POWER_CONTROL, 16'h0010);
    step(1); `CHK("pll_off", 1'b1, plloff)
    energy_detect_power_down = 1'b0;
    step(1); `CHK("pll_off", 1'b0, plloff)
    $display("test pll done");
    wr_reg(ADDR_ANALOG_FRONTEND_CONTROL, 16'h0020);
    step(1); `CHK("slow_osc", 1'b1, slow_osc)
    `CHK("xtal_off", 1'b1, xtal_off)
    `CHK("afe_pd", 1'b1, afe_pd)
    wr_reg(ADDR_ANALOG_FRONTEND_CONTROL, 16'h0000);
    step(1); `CHK("afe_pd", 1'b0, afe_pd)
    `CHK("slow_osc", 1'b0, slow_osc)
    $display("test oscillator done");
    rx_err = 1'b1;
    step(3);
    rx_err = 1'b0;
    wr_reg(ADDR_SYMBOL_ERROR_FRAME_COUNTER, 16'hffff);
    rd_reg(ADDR_SYMBOL_ERROR_FRAME_COUNTER, got); `CHK("err_cnt", 16'h0003, got)
    rd_reg(ADDR_SYMBOL_ERROR_FRAME_COUNTER, got); `CHK("err_cnt", 16'h0000, got)
    $display("test counter done");
    wake_ev = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      pin_mode = 2'(i);
      step(2); `CHK("wake_pins", {pin_mode[0], pin_mode[1]}, pins)
    end
    wr_reg(ADDR_STRAP_OVERRIDE_CONTROL, 16'h0200);
    step(1); `CHK("wake_pins", 2'h0, pins)
    `CHK("bcast_off", 1'b1, bcast_off)
    wr_reg(ADDR_STRAP_OVERRIDE_CONTROL, 16'hffff);
    rd_reg(ADDR_STRAP_OVERRIDE_CONTROL, got); `CHK("reg16", 16'hfbff, got)
    $display("test strap override done");
    stop_test();
  end
endmodule : tb
